// ===== core/io3_regs.svh
`ifndef IO3_REGS_SVH
`define IO3_REGS_SVH

// command codes that change the role of the data lines
`define IO3_CMD_QUAD_PROG 8'h32
`define IO3_CMD_QUAD_READ 8'h6b

// frame layout
`define IO3_ADDR_BYTES 2'h3
`define IO3_DUMMY_BYTES 2'h1

// receive buffer depth in bytes
`define IO3_FIFO_DEPTH 8

`endif

// ===== core/io3_pkg.sv
package io3_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA,
		ST_DONE
	} frame_e;

	// the four data lines as seen at the pins
	typedef struct packed {
		logic [3:0] in;
		logic [3:0] out;
		logic [3:0] oe;
	} lines_s;

	typedef logic [7:0] byte_t;

endpackage

// ===== core/io3_edge.sv
`timescale 1ns/10ps
module io3_edge (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// sampled level
	input wire logic i_level,
	input wire logic i_init,
	// edge pulses
	output logic o_rise,
	output logic o_fall
);
	logic prev_q;
	logic prev_d;

	always_comb begin
		prev_d = i_level;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
		end
	end

	// a level that was high at release must not look like a rise
	logic armed_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	assign o_rise = armed_q & i_level & ~prev_q & ~i_init;
	assign o_fall = armed_q & ~i_level & prev_q;
endmodule

// ===== core/io3_fifo.sv
`timescale 1ns/10ps
module io3_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// filling side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// draining side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;
	logic valid_q, valid_d;
	logic [WIDTH-1:0] data_q, data_d;

	always_comb begin
		push = i_in_valid && (cnt_q != (AW+1)'(DEPTH));
		pop = i_out_ready && (cnt_q != '0);
		wr_d = wr_q;
		rd_d = rd_q;
		if (push) begin
			wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
		end
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		// registered head; a word written into the head slot is passed straight through
		valid_d = (cnt_d != '0);
		data_d = (push && (rd_d == wr_q)) ? i_in_data : mem_q[rd_d];
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			valid_q <= 1'b0;
			data_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			valid_q <= valid_d;
			data_q <= data_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = valid_q;
	assign o_out_data = data_q;
endmodule

// ===== core/io3_front.sv
`timescale 1ns/10ps
`include "io3_regs.svh"
// How it works
// - while pause is held low, clock and input are ignored, outputs float.
// - pause suspends the link only; busy internal cycles keep running.
// - during command 32h, line three is an input; four bits per rising edge.
// - during quad reads, all four lines drive a nibble each falling edge.
// - quad enable clear: line three is pause or reset, chosen by select bit.
// - quad enable set: pause and reset are off, line three carries data.
// - frames open on select falling and close on select rising; idle ignores input.
// - inputs taken on rising clock edges, outputs changed on falling edges.
module io3_front #(
	parameter int FIFO_DEPTH = `IO3_FIFO_DEPTH
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// serial pins
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe,
	// configuration bits
	input wire logic i_quad_enable,
	input wire logic i_reset_select,
	// internal array state
	input wire logic i_array_busy,
	// status
	output logic o_paused,
	output logic o_line_reset,
	output logic o_busy,
	output logic [7:0] o_cmd,
	output logic o_overrun,
	// received bytes
	output logic o_rx_valid,
	output io3_pkg::byte_t o_rx_data,
	input wire logic i_rx_ready,
	// read data to send
	input wire logic i_read_phase,
	input wire io3_pkg::byte_t i_tx_data,
	output logic o_tx_take
);
	import io3_pkg::*;

	// ----------------------------------------
	// pin roles
	// ----------------------------------------
	logic sck_rise, sck_fall, cs_fall;
	logic pause_mode, reset_mode, reset_req;

	io3_edge u_sck_edge (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_level(i_sck),
		.i_init(1'b0),
		.o_rise(sck_rise),
		.o_fall(sck_fall)
	);

	io3_edge u_cs_edge (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_level(~i_cs_n),
		.i_init(1'b0),
		.o_rise(cs_fall),
		.o_fall()
	);

	always_comb begin
		pause_mode = ~i_quad_enable & ~i_reset_select;
		reset_mode = ~i_quad_enable & i_reset_select;
		reset_req = reset_mode & ~i_io[3];
	end

	// ----------------------------------------
	// pause tracking
	// ----------------------------------------
	logic hold_q, hold_d;

	always_comb begin
		hold_d = hold_q;
		if (!pause_mode || i_cs_n) begin
			hold_d = 1'b0;
		end else if (!hold_q && !i_io[3] && !i_sck) begin
			hold_d = 1'b1;
		end else if (hold_q && i_io[3]) begin
			hold_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hold_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
		end
	end

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	frame_e st_q, st_d;
	logic [7:0] cmd_q, cmd_d, sh_q, sh_d, tx_q, tx_d;
	logic [2:0] bit_q, bit_d;
	logic [1:0] cnt_q, cnt_d;
	logic [3:0] out_q, out_d, oe_q, oe_d;
	logic pend_q, pend_d, ovr_q, ovr_d, take_q, take_d;
	logic [7:0] pend_data_q, pend_data_d;
	logic live, quad_in, quad_out, byte_done, fifo_ready;
	logic [7:0] sh_next;
	logic [2:0] bit_next;

	always_comb begin
		live = !i_cs_n && !hold_q && !reset_req;
		quad_in = i_quad_enable && (st_q == ST_DATA) && (cmd_q == `IO3_CMD_QUAD_PROG);
		quad_out = i_quad_enable && (st_q == ST_DATA) && (cmd_q == `IO3_CMD_QUAD_READ);
		if (quad_in) begin
			sh_next = {sh_q[3:0], i_io};
		end else begin
			sh_next = {sh_q[6:0], i_io[0]};
		end
		// a quad byte is two nibbles in either direction
		bit_next = (quad_in || quad_out) ? bit_q + 3'h4 : bit_q + 3'h1;
		byte_done = (bit_next == 3'h0);

		st_d = st_q;
		cmd_d = cmd_q;
		sh_d = sh_q;
		bit_d = bit_q;
		cnt_d = cnt_q;
		tx_d = tx_q;
		out_d = out_q;
		oe_d = oe_q;
		take_d = 1'b0;
		pend_d = pend_q;
		pend_data_d = pend_data_q;
		ovr_d = ovr_q;
		if (pend_q && fifo_ready) begin
			pend_d = 1'b0;
		end

		if (i_cs_n || reset_req) begin
			// select high or line reset: back to idle, lines released
			st_d = ST_IDLE;
			bit_d = 3'h0;
			cnt_d = 2'h0;
			oe_d = 4'h0;
		end else if (hold_q) begin
			oe_d = 4'h0;
		end else begin
			if (st_q == ST_IDLE && cs_fall) begin
				st_d = ST_CMD;
			end
			if (live && sck_rise && st_q != ST_IDLE && st_q != ST_DONE) begin
				sh_d = sh_next;
				bit_d = bit_next;
				if (byte_done) begin
					case (st_q)
						ST_CMD: begin
							cmd_d = sh_next;
							st_d = ST_ADDR;
							cnt_d = 2'h0;
						end
						ST_ADDR: begin
							cnt_d = cnt_q + 2'h1;
							if (cnt_q + 2'h1 == `IO3_ADDR_BYTES) begin
								cnt_d = 2'h0;
								st_d = (cmd_q == `IO3_CMD_QUAD_READ) ? ST_DUMMY : ST_DATA;
							end
						end
						ST_DUMMY: begin
							cnt_d = cnt_q + 2'h1;
							if (cnt_q + 2'h1 == `IO3_DUMMY_BYTES) begin
								st_d = ST_DATA;
							end
						end
						ST_DATA: begin
							if (!quad_out && !i_read_phase) begin
								if (pend_q && !fifo_ready) begin
									ovr_d = 1'b1;
								end
								pend_d = 1'b1;
								pend_data_d = sh_next;
							end
						end
						default: begin
							st_d = ST_IDLE;
						end
					endcase
				end
			end
			if (live && sck_fall && st_q == ST_DATA && (quad_out || i_read_phase)) begin
				// output changes only after a falling edge
				if (bit_q == 3'h0) begin
					take_d = 1'b1;
					if (quad_out) begin
						out_d = i_tx_data[7:4];
						oe_d = 4'hf;
						tx_d = {i_tx_data[3:0], 4'h0};
					end else begin
						out_d = {2'b00, i_tx_data[7], 1'b0};
						oe_d = 4'h2;
						tx_d = {i_tx_data[6:0], 1'b0};
					end
				end else if (quad_out) begin
					out_d = tx_q[7:4];
					tx_d = {tx_q[3:0], 4'h0};
				end else begin
					out_d = {2'b00, tx_q[7], 1'b0};
					tx_d = {tx_q[6:0], 1'b0};
				end
			end
			if (st_q == ST_DATA && !quad_out && !i_read_phase) begin
				oe_d = 4'h0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= ST_IDLE;
			cmd_q <= 8'h00;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			cnt_q <= 2'h0;
			tx_q <= 8'h00;
			out_q <= 4'h0;
			oe_q <= 4'h0;
			take_q <= 1'b0;
			pend_q <= 1'b0;
			pend_data_q <= 8'h00;
			ovr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			cnt_q <= cnt_d;
			tx_q <= tx_d;
			out_q <= out_d;
			oe_q <= oe_d;
			take_q <= take_d;
			pend_q <= pend_d;
			pend_data_q <= pend_data_d;
			ovr_q <= ovr_d;
		end
	end

	// ----------------------------------------
	// receive buffer
	// ----------------------------------------
	io3_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_in_valid(pend_q),
		.i_in_data(pend_data_q),
		.o_in_ready(fifo_ready),
		.o_out_valid(o_rx_valid),
		.o_out_data(o_rx_data),
		.i_out_ready(i_rx_ready)
	);

	// ----------------------------------------
	// status registers
	// ----------------------------------------
	logic rst_q, busy_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			rst_q <= reset_req;
			busy_q <= i_array_busy;
		end
	end

	assign o_io = out_q;
	assign o_io_oe = oe_q;
	assign o_paused = hold_q;
	assign o_line_reset = rst_q;
	assign o_busy = busy_q;
	assign o_cmd = cmd_q;
	assign o_overrun = ovr_q;
	assign o_tx_take = take_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_pause_seen;
		hold_q && !i_cs_n;
	endsequence

	a_pause_floats: assert property (s_pause_seen |=> oe_q == 4'h0) else $error("lines driven in pause");
	a_pause_freezes: assert property (hold_q && hold_d |=> $stable(sh_q) && $stable(bit_q))
		else $error("shift moved in pause");
	a_pause_start: assert property (!hold_q && hold_d |-> !i_cs_n && !i_sck && pause_mode)
		else $error("pause began illegally");
	a_busy_follows: assert property (hold_q |=> o_busy == $past(i_array_busy)) else $error("busy lost in pause");
	a_quad_prog_in: assert property (quad_in |-> oe_q[3] == 1'b0) else $error("line three driven in 32h");
	a_quad_read_out: assert property (live && sck_fall && quad_out |=> oe_q == 4'hf) else $error("quad read not driven");
	a_qe_no_pause: assert property (i_quad_enable |=> !hold_q) else $error("pause with quad enable");
	a_reset_pause: assert property (i_reset_select |=> !hold_q) else $error("pause in reset role");
	a_idle_deselect: assert property (i_cs_n |=> st_q == ST_IDLE && oe_q == 4'h0) else $error("active while deselected");
	a_fall_only_out: assert property (!sck_fall |=> $stable(out_q)) else $error("output moved off falling edge");
	a_line_reset: assert property (reset_req ##1 reset_req |-> st_q == ST_IDLE) else $error("reset did not abort");
endmodule

// ===== verification/host.sv
`timescale 1ns/10ps
// -------------------------------------------
// host controller: clock, select, data lines
// -------------------------------------------
module host (
	// clock
	input wire logic i_clk,
	// device side
	input wire logic [3:0] i_dev_io,
	input wire logic [3:0] i_dev_oe,
	// host pins
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_io
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'hf;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// data changes with the falling clock; device lines are looked at just before the rise
	task automatic bit_out(input logic [3:0] d, output logic [7:0] q);
		o_sck <= 1'b0;
		o_io <= d;
		wt(4);
		q = {i_dev_oe, i_dev_io};
		o_sck <= 1'b1;
		wt(4);
	endtask

	task automatic nib_out(input logic [7:0] b);
		logic [7:0] q;
		bit_out(b[7:4], q);
		bit_out(b[3:0], q);
	endtask

	task automatic sel();
		o_sck <= 1'b0;
		wt(2);
		o_cs_n <= 1'b0;
		wt(4);
	endtask

	task automatic desel();
		o_sck <= 1'b0;
		wt(4);
		o_cs_n <= 1'b1;
		wt(4);
	endtask

	// line three only goes low with select low and the clock low
	task automatic hold_low(input logic v);
		o_sck <= 1'b0;
		wt(2);
		o_io <= {v, 3'b111};
		wt(4);
	endtask

	// clock and data keep moving while line three is held low
	task automatic wiggle();
		for (int i = 0; i < 4; i++) begin
			o_sck <= ~o_sck;
			o_io <= {1'b0, 2'b11, ~o_io[0]};
			wt(4);
		end
	endtask
endmodule

// ===== verification/test_flash_pause_reset_io3_pin.sv
`timescale 1ns/10ps
module test_flash_pause_reset_io3_pin;
	import io3_pkg::*;
	logic clk, arst_n, qe, rsel, abusy, rx_ready, rd_phase;
	byte_t tx_data, rx_data, cmd;
	logic [3:0] dev_io, dev_oe, h_io, pins;
	logic sck, cs_n, paused, lreset, busy, overrun, rx_valid, take;
	int fail_count = 0;
	int checks = 0;
	int n_take = 0;

	// counts pulses of the send strobe
	always @(posedge clk) begin
		if (take === 1'b1) begin
			n_take <= n_take + 1;
		end
	end

	assign pins = (dev_oe & dev_io) | (~dev_oe & h_io);

	io3_front u_io3_front (.i_clk(clk), .i_arst_n(arst_n), .i_sck(sck), .i_cs_n(cs_n), .i_io(pins),
		.o_io(dev_io), .o_io_oe(dev_oe), .i_quad_enable(qe), .i_reset_select(rsel), .i_array_busy(abusy),
		.o_paused(paused), .o_line_reset(lreset), .o_busy(busy), .o_cmd(cmd), .o_overrun(overrun),
		.o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready), .i_read_phase(rd_phase),
		.i_tx_data(tx_data), .o_tx_take(take));
	host u_host (.i_clk(clk), .i_dev_io(dev_io), .i_dev_oe(dev_oe), .o_sck(sck), .o_cs_n(cs_n), .o_io(h_io));

	// -------------------------------------------
	// helpers
	// -------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic bits(input byte_t b, input int hi, input int lo);
		logic [7:0] q;
		for (int i = hi; i >= lo; i--) begin
			u_host.bit_out({3'b111, b[i]}, q);
		end
	endtask

	task automatic header(input byte_t c);
		u_host.sel();
		for (int i = 0; i < 4; i++) begin
			bits(i == 0 ? c : 8'h00, 7, 0);
		end
	endtask

	// -------------------------------------------
	// scenarios
	// -------------------------------------------
	task automatic t_quad_prog();
		qe <= 1'b1;
		header(8'h32);
		for (int i = 0; i < 10; i++) begin
			u_host.nib_out(8'h70 + i[7:0]);
		end
		u_host.desel();
		chk("cmd", 8'h32, cmd);
		chk("overrun", 8'h01, {7'h0, overrun});
		for (int i = 0; i < 8; i++) begin
			chk("rx valid", 8'h01, {7'h0, rx_valid});
			chk("rx data", 8'h70 + i[7:0], rx_data);
			rx_ready <= 1'b1;
			wt(1);
			rx_ready <= 1'b0;
			wt(1);
		end
	endtask

	task automatic t_quad_read();
		logic [7:0] q;
		tx_data <= 8'h5c;
		header(8'h6b);
		bits(8'h00, 7, 0);
		u_host.bit_out(4'ha, q);
		chk("read hi", 8'hf5, q);
		tx_data <= 8'h93;
		u_host.bit_out(4'h5, q);
		chk("read lo", 8'hfc, q);
		u_host.bit_out(4'ha, q);
		chk("read next hi", 8'hf9, q);
		u_host.bit_out(4'h5, q);
		chk("read next lo", 8'hf3, q);
		chk("tx take", 8'h02, 8'(n_take));
		u_host.desel();
		chk("oe idle", 8'h00, {4'h0, dev_oe});
	endtask

	task automatic t_single_read();
		logic [7:0] q;
		int t0;
		tx_data <= 8'ha6;
		rd_phase <= 1'b1;
		header(8'h03);
		t0 = n_take;
		for (int i = 7; i >= 0; i--) begin
			u_host.bit_out(4'hf, q);
			chk("single read", {4'h2, 2'h0, tx_data[i], 1'b0}, q);
		end
		chk("single take", 8'h01, 8'(n_take - t0));
		u_host.desel();
		chk("single oe idle", 8'h00, {4'h0, dev_oe});
		rd_phase <= 1'b0;
	endtask

	task automatic t_pause();
		qe <= 1'b0;
		rsel <= 1'b0;
		u_host.sel();
		bits(8'ha5, 7, 4);
		u_host.hold_low(1'b0);
		abusy <= 1'b1;
		wt(2);
		chk("paused", 8'h01, {7'h0, paused});
		u_host.wiggle();
		chk("oe", 8'h00, {4'h0, dev_oe});
		chk("busy", 8'h01, {7'h0, busy});
		u_host.hold_low(1'b1);
		chk("resumed", 8'h00, {7'h0, paused});
		bits(8'ha5, 3, 0);
		wt(4);
		chk("cmd", 8'ha5, cmd);
		u_host.desel();
		abusy <= 1'b0;
	endtask

	task automatic t_line_reset();
		bits(8'h77, 7, 0);
		wt(2);
		chk("cmd deselected", 8'ha5, cmd);
		rsel <= 1'b1;
		u_host.sel();
		bits(8'h3c, 7, 4);
		u_host.hold_low(1'b0);
		wt(2);
		chk("line reset", 8'h01, {7'h0, lreset});
		u_host.hold_low(1'b1);
		bits(8'h9f, 7, 0);
		wt(4);
		chk("cmd aborted", 8'ha5, cmd);
		u_host.desel();
		u_host.sel();
		bits(8'h9f, 7, 0);
		wt(4);
		chk("cmd new", 8'h9f, cmd);
		u_host.desel();
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		arst_n = 1'b0;
		qe = 1'b0;
		rsel = 1'b0;
		abusy = 1'b0;
		rx_ready = 1'b0;
		rd_phase = 1'b0;
		tx_data = 8'h00;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		wt(2);
		t_quad_prog();
		t_quad_read();
		t_single_read();
		t_pause();
		t_line_reset();
		results();
	end

	initial begin
		#2000000;
		fail_count++;
		results();
	end
endmodule
